// ---- src/insn_exec_pkg.sv ----
// Constants, types and register map shared by the instruction execution block
package insn_exec_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_INSN      = 8'h00;
	localparam logic [7:0] OFS_ACC       = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_PC        = 8'h0c;
	localparam logic [7:0] OFS_MEM_PTR   = 8'h10;
	localparam logic [7:0] OFS_MEM_DATA  = 8'h14;
	localparam logic [7:0] OFS_STACK     = 8'h18;
	localparam logic [7:0] OFS_WDOG      = 8'h1c;

	// Instruction word field positions
	localparam int INSN_OP_LSB    = 0;
	localparam int INSN_BIT_LSB   = 5;
	localparam int INSN_ADDR_LSB  = 8;
	localparam int INSN_IMM_LSB   = 16;
	localparam int INSN_TGT_LSB   = 16;

	// Status register bit positions
	localparam int ST_UWRAP  = 0;
	localparam int ST_HWRAP  = 1;
	localparam int ST_NULL   = 2;
	localparam int ST_SWRAP  = 3;
	localparam int ST_SLEEP  = 4;
	localparam int ST_EXPIRY = 5;

	// Sizes
	localparam int MEM_WORDS    = 128;
	localparam int STACK_LEVELS = 6;
	localparam logic [2:0] STACK_TOP = 3'h5;

	// Decimal adjust constants
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [3:0] BCD_FIX       = 4'h6;

	// Reset values
	localparam logic [7:0]  ACC_RST = 8'h00;
	localparam logic [11:0] PC_RST  = 12'h000;

	typedef enum logic [4:0] {
		op_none             = 5'h00,
		op_sum_carry_acc    = 5'h01,
		op_sum_carry_mem    = 5'h02,
		op_sum_acc          = 5'h03,
		op_sum_mem          = 5'h04,
		op_sum_imm          = 5'h05,
		op_conj_acc         = 5'h06,
		op_conj_imm         = 5'h07,
		op_conj_mem         = 5'h08,
		op_subroutine_jump  = 5'h09,
		op_zero_fill_mem    = 5'h0a,
		op_bit_zero         = 5'h0b,
		op_watchdog_kick    = 5'h0c,
		op_preclear_first   = 5'h0d,
		op_preclear_second  = 5'h0e,
		op_invert_mem       = 5'h0f,
		op_invert_to_a      = 5'h10,
		op_bcd_adjust       = 5'h11,
		op_minus_one_mem    = 5'h12,
		op_minus_one_to_a   = 5'h13
	} op_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic expiry;
		logic sleep;
		logic swrap;
		logic nullr;
		logic hwrap;
		logic uwrap;
	} flags_s;

	typedef struct packed {
		logic [7:0] res;
		logic       uwrap;
		logic       hwrap;
		logic       swrap;
	} sum_s;

endpackage

// ---- src/insn_exec.sv ----
// Instruction execution datapath with APB register access
//
// Overview of operation
// - Sum with carry: acc + byte + carry into acc, four arithmetic flags.
// - Sum with carry into memory: same sum written back, same four flags.
// - Sum: acc + byte into acc, four arithmetic flags updated.
// - Sum into memory: acc + byte written back, four flags updated.
// - Immediate sum: acc + 8-bit immediate into acc, four flags.
// - Conjunction acc with byte into acc, only null flag.
// - Conjunction acc with immediate into acc, only null flag.
// - Conjunction into memory, only null flag.
// - Subroutine jump pushes pc+1, loads target, no flags.
// - Zero fill writes zero to byte, no flags change.
// - Bit clear zeroes one selected bit, no flags change.
// - Watchdog kick clears counter, prescaler, sleep and expiry bits.
// - Second preclear after the other clears watchdog, sleep, expiry.
// - Lone preclear only records that it ran.
// - Invert memory byte in place, only null flag.
// - Invert byte into acc, byte unchanged, only null flag.
// - Low nibble above 9 or half wrap: add 6, carry up only if that overflows the nibble.
// - High nibble plus carry above 9 or wrap: add 6, set wrap.
// - Adjusted byte goes to memory; only unsigned wrap may change.
// - Minus one in memory, only null flag.
// - Byte minus one into acc, byte unchanged, only null flag.
// - Memory address is 7 bits, immediates are 8 bits.
// - Subroutine target is a 12-bit program address.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module insn_exec #(
	parameter int PRESCALE_DIV = 256
) (
	// Clock and reset
	input  wire logic                    CLK_SYS,
	input  wire logic                    RESET_N,
	// APB slave
	input  wire insn_exec_pkg::apb_req_s APB_REQ,
	output var  insn_exec_pkg::apb_rsp_s APB_RSP
);

	generate
		if (PRESCALE_DIV < 1 || PRESCALE_DIV > 256)
		begin : g_bad_div
			$error("PRESCALE_DIV must lie in 1..256");
		end
	endgenerate

	localparam logic [7:0] DIV_LAST = 8'(PRESCALE_DIV - 1);

	typedef struct packed {
		logic [7:0]                                       acc;
		insn_exec_pkg::flags_s                            flags;
		logic [11:0]                                      pc;
		logic [2:0]                                       sp;
		logic [insn_exec_pkg::STACK_LEVELS-1:0][11:0]     stack;
		logic [insn_exec_pkg::MEM_WORDS-1:0][7:0]         mem;
		logic [6:0]                                       mem_ptr;
		logic [31:0]                                      last_insn;
		logic [7:0]                                       prescale;
		logic [7:0]                                       wcount;
		logic                                             pre_first;
		logic                                             pre_second;
		insn_exec_pkg::apb_rsp_s                          rsp;
	} state_s;

	state_s cur_ff;
	state_s nxt_state;

	logic                  commit;
	logic                  hit;
	logic                  do_exec;
	logic [31:0]           rd_word;
	insn_exec_pkg::op_e    op;
	logic [2:0]            bit_sel;
	logic [6:0]            maddr;
	logic [7:0]            imm;
	logic [11:0]           target;
	logic [7:0]            mval;
	insn_exec_pkg::sum_s   sum;
	logic [4:0]            lo5;
	logic                  lo_fix;
	logic                  carry_lo;
	logic [3:0]            lo_res;
	logic [4:0]            hi5;
	logic [4:0]            hi_fix5;
	logic                  wd_clear;
	logic                  expire;

	function automatic insn_exec_pkg::sum_s add8(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       cin
	);
		insn_exec_pkg::sum_s r;
		logic [8:0]          s;
		logic [4:0]          l;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res   = s[7:0];
		r.uwrap = s[8];
		r.hwrap = l[4];
		r.swrap = (a[7] == b[7]) && (s[7] != a[7]);
		return r;
	endfunction

	function automatic logic is_null(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	// Register read mux
	always_comb
	begin
		hit = 1'b1;
		case (APB_REQ.paddr)
			insn_exec_pkg::OFS_INSN:
				rd_word = cur_ff.last_insn;
			insn_exec_pkg::OFS_ACC:
				rd_word = {24'h000000, cur_ff.acc};
			insn_exec_pkg::OFS_STATUS:
				rd_word = {26'h0000000, cur_ff.flags};
			insn_exec_pkg::OFS_PC:
				rd_word = {20'h00000, cur_ff.pc};
			insn_exec_pkg::OFS_MEM_PTR:
				rd_word = {25'h0000000, cur_ff.mem_ptr};
			insn_exec_pkg::OFS_MEM_DATA:
				rd_word = {24'h000000, cur_ff.mem[cur_ff.mem_ptr]};
			insn_exec_pkg::OFS_STACK:
				rd_word = {4'h0, cur_ff.stack[cur_ff.sp], 13'h0000, cur_ff.sp};
			insn_exec_pkg::OFS_WDOG:
				rd_word = {16'h0000, cur_ff.prescale, cur_ff.wcount};
			default:
			begin
				rd_word = 32'h00000000;
				hit = 1'b0;
			end
		endcase
	end

	// Instruction field decode
	always_comb
	begin
		maddr   = APB_REQ.pwdata[insn_exec_pkg::INSN_ADDR_LSB +: 7];
		imm     = APB_REQ.pwdata[insn_exec_pkg::INSN_IMM_LSB +: 8];
		target  = APB_REQ.pwdata[insn_exec_pkg::INSN_TGT_LSB +: 12];
		bit_sel = APB_REQ.pwdata[insn_exec_pkg::INSN_BIT_LSB +: 3];
		op      = insn_exec_pkg::op_e'(APB_REQ.pwdata[4:0]);
		mval    = cur_ff.mem[maddr];
	end

	// Decimal adjust arithmetic
	always_comb
	begin
		lo5      = {1'b0, cur_ff.acc[3:0]} + {1'b0, insn_exec_pkg::BCD_FIX};
		lo_fix   = (cur_ff.acc[3:0] > insn_exec_pkg::BCD_DIGIT_MAX) ||
			cur_ff.flags.hwrap;
		carry_lo = lo_fix & lo5[4];
		lo_res   = lo_fix ? lo5[3:0] : cur_ff.acc[3:0];
		hi5      = {1'b0, cur_ff.acc[7:4]} + {4'h0, carry_lo};
		hi_fix5  = hi5 + {1'b0, insn_exec_pkg::BCD_FIX};
	end

	// Bus handshake: one wait state, the access completes on the
	// second access-phase edge so a write acts only when pready is seen.
	assign commit  = APB_REQ.psel & APB_REQ.penable & cur_ff.rsp.pready;
	assign do_exec = commit & APB_REQ.pwrite &
		(APB_REQ.paddr == insn_exec_pkg::OFS_INSN);

	always_comb
	begin
		nxt_state = cur_ff;
		sum       = add8(8'h00, 8'h00, 1'b0);
		wd_clear  = 1'b0;

		// Response path
		nxt_state.rsp.pready = 1'b0;
		if (APB_REQ.psel && APB_REQ.penable && !cur_ff.rsp.pready)
		begin
			nxt_state.rsp.pready  = 1'b1;
			nxt_state.rsp.pslverr = ~hit;
			nxt_state.rsp.prdata  = APB_REQ.pwrite ? 32'h00000000 : rd_word;
		end

		// Plain register writes
		if (commit && APB_REQ.pwrite)
		begin
			case (APB_REQ.paddr)
				insn_exec_pkg::OFS_ACC:
					nxt_state.acc = APB_REQ.pwdata[7:0];
				insn_exec_pkg::OFS_STATUS:
					nxt_state.flags = APB_REQ.pwdata[5:0];
				insn_exec_pkg::OFS_PC:
					nxt_state.pc = APB_REQ.pwdata[11:0];
				insn_exec_pkg::OFS_MEM_PTR:
					nxt_state.mem_ptr = APB_REQ.pwdata[6:0];
				insn_exec_pkg::OFS_MEM_DATA:
					nxt_state.mem[cur_ff.mem_ptr] = APB_REQ.pwdata[7:0];
				default:
					nxt_state.last_insn = cur_ff.last_insn;
			endcase
		end

		// Instruction execution
		if (do_exec)
		begin
			nxt_state.last_insn = APB_REQ.pwdata;
			nxt_state.pc        = cur_ff.pc + 12'h001;
			case (op)
				insn_exec_pkg::op_sum_carry_acc:
				begin
					sum = add8(cur_ff.acc, mval, cur_ff.flags.uwrap);
					nxt_state.acc = sum.res;
				end
				insn_exec_pkg::op_sum_carry_mem:
				begin
					sum = add8(cur_ff.acc, mval, cur_ff.flags.uwrap);
					nxt_state.mem[maddr] = sum.res;
				end
				insn_exec_pkg::op_sum_acc:
				begin
					sum = add8(cur_ff.acc, mval, 1'b0);
					nxt_state.acc = sum.res;
				end
				insn_exec_pkg::op_sum_mem:
				begin
					sum = add8(cur_ff.acc, mval, 1'b0);
					nxt_state.mem[maddr] = sum.res;
				end
				insn_exec_pkg::op_sum_imm:
				begin
					sum = add8(cur_ff.acc, imm, 1'b0);
					nxt_state.acc = sum.res;
				end
				insn_exec_pkg::op_conj_acc:
				begin
					nxt_state.acc = cur_ff.acc & mval;
					nxt_state.flags.nullr = is_null(cur_ff.acc & mval);
				end
				insn_exec_pkg::op_conj_imm:
				begin
					nxt_state.acc = cur_ff.acc & imm;
					nxt_state.flags.nullr = is_null(cur_ff.acc & imm);
				end
				insn_exec_pkg::op_conj_mem:
				begin
					nxt_state.mem[maddr] = cur_ff.acc & mval;
					nxt_state.flags.nullr = is_null(cur_ff.acc & mval);
				end
				insn_exec_pkg::op_subroutine_jump:
				begin
					nxt_state.stack[cur_ff.sp] = cur_ff.pc + 12'h001;
					nxt_state.sp = (cur_ff.sp == insn_exec_pkg::STACK_TOP) ?
						3'h0 : cur_ff.sp + 3'h1;
					nxt_state.pc = target;
				end
				insn_exec_pkg::op_zero_fill_mem:
					nxt_state.mem[maddr] = 8'h00;
				insn_exec_pkg::op_bit_zero:
					nxt_state.mem[maddr][bit_sel] = 1'b0;
				insn_exec_pkg::op_watchdog_kick:
					wd_clear = 1'b1;
				insn_exec_pkg::op_preclear_first:
				begin
					if (cur_ff.pre_second)
					begin
						wd_clear = 1'b1;
					end
					else
					begin
						nxt_state.pre_first = 1'b1;
					end
				end
				insn_exec_pkg::op_preclear_second:
				begin
					if (cur_ff.pre_first)
					begin
						wd_clear = 1'b1;
					end
					else
					begin
						nxt_state.pre_second = 1'b1;
					end
				end
				insn_exec_pkg::op_invert_mem:
				begin
					nxt_state.mem[maddr] = ~mval;
					nxt_state.flags.nullr = is_null(~mval);
				end
				insn_exec_pkg::op_invert_to_a:
				begin
					nxt_state.acc = ~mval;
					nxt_state.flags.nullr = is_null(~mval);
				end
				insn_exec_pkg::op_bcd_adjust:
				begin
					if (hi5 > {1'b0, insn_exec_pkg::BCD_DIGIT_MAX} ||
						cur_ff.flags.uwrap)
					begin
						nxt_state.mem[maddr] = {hi_fix5[3:0], lo_res};
						nxt_state.flags.uwrap = 1'b1;
					end
					else
					begin
						nxt_state.mem[maddr] = {hi5[3:0], lo_res};
					end
				end
				insn_exec_pkg::op_minus_one_mem:
				begin
					nxt_state.mem[maddr] = mval - 8'h01;
					nxt_state.flags.nullr = is_null(mval - 8'h01);
				end
				insn_exec_pkg::op_minus_one_to_a:
				begin
					nxt_state.acc = mval - 8'h01;
					nxt_state.flags.nullr = is_null(mval - 8'h01);
				end
				default:
					nxt_state.pc = cur_ff.pc + 12'h001;
			endcase

			// Arithmetic flag update shared by the sum group
			case (op)
				insn_exec_pkg::op_sum_carry_acc,
				insn_exec_pkg::op_sum_carry_mem,
				insn_exec_pkg::op_sum_acc,
				insn_exec_pkg::op_sum_mem,
				insn_exec_pkg::op_sum_imm:
				begin
					nxt_state.flags.uwrap = sum.uwrap;
					nxt_state.flags.hwrap = sum.hwrap;
					nxt_state.flags.swrap = sum.swrap;
					nxt_state.flags.nullr = is_null(sum.res);
				end
				default:
					nxt_state.flags.nullr = nxt_state.flags.nullr;
			endcase
		end

		// Watchdog timebase
		expire = 1'b0;
		if (cur_ff.prescale == DIV_LAST)
		begin
			nxt_state.prescale = 8'h00;
			nxt_state.wcount   = cur_ff.wcount + 8'h01;
			expire             = (cur_ff.wcount == 8'hff);
		end
		else
		begin
			nxt_state.prescale = cur_ff.prescale + 8'h01;
		end

		// Restart counting and drop status bits
		if (wd_clear)
		begin
			nxt_state.prescale     = 8'h00;
			nxt_state.wcount       = 8'h00;
			nxt_state.flags.sleep  = 1'b0;
			nxt_state.flags.expiry = 1'b0;
			nxt_state.pre_first    = 1'b0;
			nxt_state.pre_second   = 1'b0;
		end

		// Expiry set wins over any clear in the same cycle
		if (expire)
		begin
			nxt_state.flags.expiry = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cur_ff       <= '0;
			cur_ff.acc   <= insn_exec_pkg::ACC_RST;
			cur_ff.pc    <= insn_exec_pkg::PC_RST;
		end
		else
		begin
			cur_ff <= nxt_state;
		end
	end

	assign APB_RSP = cur_ff.rsp;

endmodule

`default_nettype wire

// ---- testbench/insn_exec_monitor.sv ----
// Checker on the APB ports of the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module insn_exec_monitor #(
	parameter int PRESCALE_DIV = 256
) (
	// Clock and reset
	input wire logic                    CLK_SYS,
	input wire logic                    RESET_N,
	// APB
	input wire insn_exec_pkg::apb_req_s APB_REQ,
	input wire insn_exec_pkg::apb_rsp_s APB_RSP
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);

	logic       rd_ok;
	logic [7:0] adr;
	logic [31:0] rdat;

	assign adr = APB_REQ.paddr;
	assign rdat = APB_RSP.prdata;
	assign rd_ok = APB_RSP.pready && !APB_REQ.pwrite;

	ready_wait_a: assert property (APB_REQ.psel && APB_REQ.penable
		&& !APB_RSP.pready |=> APB_RSP.pready)
		else $error("pready not one cycle after access");
	ready_pulse_a: assert property (APB_RSP.pready |=> !APB_RSP.pready)
		else $error("pready longer than one cycle");
	ready_phase_a: assert property (APB_RSP.pready
		|-> APB_REQ.psel && APB_REQ.penable)
		else $error("pready outside access phase");
	// Only a decode miss may answer with an error
	err_unmapped_a: assert property (APB_RSP.pready && adr > 8'h1c
		|-> APB_RSP.pslverr && rdat == 32'h0)
		else $error("unmapped access not refused");
	err_mapped_a: assert property (APB_RSP.pready && adr <= 8'h1c
		&& adr[1:0] == 2'h0 |-> !APB_RSP.pslverr)
		else $error("mapped access refused");
	acc_width_a: assert property (
		rd_ok && adr == insn_exec_pkg::OFS_ACC |-> rdat[31:8] == 24'h0)
		else $error("accumulator wider than a byte");
	ptr_width_a: assert property (
		rd_ok && adr == insn_exec_pkg::OFS_MEM_PTR |-> rdat[31:7] == 25'h0)
		else $error("memory address wider than 7 bits");
	pc_width_a: assert property (
		rd_ok && adr == insn_exec_pkg::OFS_PC |-> rdat[31:12] == 20'h0)
		else $error("program counter wider than 12 bits");
	stack_depth_a: assert property (
		rd_ok && adr == insn_exec_pkg::OFS_STACK
		|-> rdat[2:0] <= insn_exec_pkg::STACK_TOP && rdat[15:3] == 13'h0
		&& rdat[31:28] == 4'h0)
		else $error("stack pointer outside six levels");
	wdog_pre_a: assert property (
		rd_ok && adr == insn_exec_pkg::OFS_WDOG
		|-> rdat[15:8] < PRESCALE_DIV && rdat[31:16] == 16'h0)
		else $error("prescaler out of range");
endmodule

bind insn_exec insn_exec_monitor #(
	.PRESCALE_DIV(PRESCALE_DIV)
) mon (
	.CLK_SYS(CLK_SYS),
	.RESET_N(RESET_N),
	.APB_REQ(APB_REQ),
	.APB_RSP(APB_RSP)
);
`default_nettype wire

// ---- testbench/insn_exec_tb.sv ----
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module insn_exec_tb;
	logic                    clk;
	logic                    rst_n;
	insn_exec_pkg::apb_req_s req;
	insn_exec_pkg::apb_rsp_s rsp;
	int                      fail_count;
	int                      checks_done;
	logic [31:0]             q;
	logic                    e;

	// Short prescale so the counter wraps in about 512 cycles
	insn_exec #(
		.PRESCALE_DIV(2)
	) dut (
		.CLK_SYS(clk),
		.RESET_N(rst_n),
		.APB_REQ(req),
		.APB_RSP(rsp)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		checks_done++;
		if (g !== x)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One APB transfer; only the bench watchdog ends a stuck wait
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic get(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] mk(input logic [4:0] op,
		input logic [11:0] v, input logic [2:0] b);
		return {4'h0, v, 1'b0, 7'h03, b, op};
	endfunction

	// Execute, then compare accumulator, byte 3 and arithmetic flags
	task automatic step(input logic [31:0] w, input logic [7:0] ea,
		input logic [7:0] em, input logic [3:0] es);
		put(insn_exec_pkg::OFS_INSN, w);
		get(insn_exec_pkg::OFS_ACC);
		chk("acc", {24'h0, ea}, q);
		get(insn_exec_pkg::OFS_MEM_DATA);
		chk("mem", {24'h0, em}, q);
		get(insn_exec_pkg::OFS_STATUS);
		chk("flags", {28'h0, es}, {28'h0, q[3:0]});
	endtask

	// Expected {expiry, sleep}
	task automatic wdflags(input logic [1:0] x);
		get(insn_exec_pkg::OFS_STATUS);
		chk("wd flags", {30'h0, x}, {30'h0, q[5:4]});
	endtask

	task automatic t_sum;
		put(insn_exec_pkg::OFS_MEM_PTR, 32'h3);
		put(insn_exec_pkg::OFS_ACC, 32'h7f);
		put(insn_exec_pkg::OFS_MEM_DATA, 32'h1);
		put(insn_exec_pkg::OFS_STATUS, 32'h1);
		step(mk(5'h01, 12'h0, 3'h0), 8'h81, 8'h01, 4'ha);
		step(mk(5'h02, 12'h0, 3'h0), 8'h81, 8'h82, 4'h0);
		step(mk(5'h04, 12'h0, 3'h0), 8'h81, 8'h03, 4'h9);
		step(mk(5'h03, 12'h0, 3'h0), 8'h84, 8'h03, 4'h0);
		step(mk(5'h05, 12'h7c, 3'h0), 8'h00, 8'h03, 4'h7);
		$display("test sum done");
	endtask

	task automatic t_logic;
		put(insn_exec_pkg::OFS_ACC, 32'hf0);
		put(insn_exec_pkg::OFS_MEM_DATA, 32'h3c);
		step(mk(5'h06, 12'h0, 3'h0), 8'h30, 8'h3c, 4'h3);
		step(mk(5'h07, 12'h0f, 3'h0), 8'h00, 8'h3c, 4'h7);
		step(mk(5'h08, 12'h0, 3'h0), 8'h00, 8'h00, 4'h7);
		step(mk(5'h0f, 12'h0, 3'h0), 8'h00, 8'hff, 4'h3);
		step(mk(5'h10, 12'h0, 3'h0), 8'h00, 8'hff, 4'h7);
		step(mk(5'h12, 12'h0, 3'h0), 8'h00, 8'hfe, 4'h3);
		step(mk(5'h13, 12'h0, 3'h0), 8'hfd, 8'hfe, 4'h3);
		step(mk(5'h0a, 12'h0, 3'h0), 8'hfd, 8'h00, 4'h3);
		put(insn_exec_pkg::OFS_MEM_DATA, 32'hff);
		step(mk(5'h0b, 12'h0, 3'h5), 8'hfd, 8'hdf, 4'h3);
		step(mk(5'h0b, 12'h0, 3'h0), 8'hfd, 8'hde, 4'h3);
		$display("test logic done");
	endtask

	task automatic t_bcd;
		put(insn_exec_pkg::OFS_STATUS, 32'h0);
		put(insn_exec_pkg::OFS_ACC, 32'h99);
		step(mk(5'h11, 12'h0, 3'h0), 8'h99, 8'h99, 4'h0);
		put(insn_exec_pkg::OFS_ACC, 32'h9a);
		step(mk(5'h11, 12'h0, 3'h0), 8'h9a, 8'h00, 4'h1);
		put(insn_exec_pkg::OFS_STATUS, 32'h2);
		put(insn_exec_pkg::OFS_ACC, 32'h28);
		step(mk(5'h11, 12'h0, 3'h0), 8'h28, 8'h2e, 4'h2);
		put(insn_exec_pkg::OFS_STATUS, 32'h1);
		put(insn_exec_pkg::OFS_ACC, 32'h12);
		step(mk(5'h11, 12'h0, 3'h0), 8'h12, 8'h72, 4'h1);
		$display("test bcd done");
	endtask

	task automatic t_call;
		put(insn_exec_pkg::OFS_PC, 32'h123);
		repeat (6)
			put(insn_exec_pkg::OFS_INSN, mk(5'h09, 12'habc, 3'h0));
		get(insn_exec_pkg::OFS_PC);
		chk("pc", 32'habc, q);
		get(insn_exec_pkg::OFS_STACK);
		chk("stack", 32'h01240000, q);
		get(insn_exec_pkg::OFS_STATUS);
		chk("flags", 32'h1, {28'h0, q[3:0]});
		put(insn_exec_pkg::OFS_INSN, mk(5'h00, 12'h0, 3'h0));
		get(insn_exec_pkg::OFS_PC);
		chk("pc next", 32'habd, q);
		put(8'h20, 32'h5);
		get(8'h20);
		chk("unmapped", 32'h1, {31'h0, e});
		$display("test call done");
	endtask

	task automatic t_wdog;
		put(insn_exec_pkg::OFS_INSN, mk(5'h0c, 12'h0, 3'h0));
		wdflags(2'h0);
		repeat (530) @(posedge clk);
		wdflags(2'h2);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0d, 12'h0, 3'h0));
		wdflags(2'h2);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0d, 12'h0, 3'h0));
		wdflags(2'h2);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0e, 12'h0, 3'h0));
		wdflags(2'h0);
		get(insn_exec_pkg::OFS_WDOG);
		chk("wd count", 32'h1, {31'h0, q[7:0] < 8'h4});
		repeat (530) @(posedge clk);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0e, 12'h0, 3'h0));
		wdflags(2'h2);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0c, 12'h0, 3'h0));
		wdflags(2'h0);
		// Sleep and expiry bits raised by software, then second-before-first pairing
		put(insn_exec_pkg::OFS_STATUS, 32'h30);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0e, 12'h0, 3'h0));
		wdflags(2'h3);
		put(insn_exec_pkg::OFS_INSN, mk(5'h0d, 12'h0, 3'h0));
		wdflags(2'h0);
		$display("test watchdog done");
	endtask

	initial
	begin
		req = '0;
		rst_n = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		get(insn_exec_pkg::OFS_ACC);
		chk("acc reset", 32'h0, q);
		t_sum();
		t_logic();
		t_bcd();
		t_call();
		t_wdog();
		final_report();
	end

	// Hang guard, well beyond the few thousand cycles the tests need
	initial
	begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
